/* hdl/lcdiag_channel.sv */
// Diagnostic logic of one line channel: sequence generator and checker,
// three loopbacks and all-ones transmission, controlled over APB in host mode; loopbacks and all-ones by pins in hardware mode.
// Assumes line clocks and pins arrive asynchronously and are oversampled.
//
// Functional notes
// R1: Sequence feature only in host mode
// R2: Send 2^23-1 at E3, 2^15-1 otherwise
// R3: Sequence enable also enables the checker
// R4: Violation output low once in lock
// R5: Out of lock: status bit set, output high
// R6: Writing insert bit corrupts one bit
// R7: Each detected error pulses one receive cycle
// R8: New insertion needs insert bit 0 then 1
// R9: Sequence mode forces single-rail data
// R10: Three loopbacks, selected by pins or register
// R11: Analog loop feeds transmit line to receiver
// R12: Analog loop ignores receive line inputs
// R13: Digital loop passes transmit clock and data
// R14: Remote loop resends received data, receive timing
// R15: Remote loop still outputs received data
// R16: Transmit-path attenuator sits after remote loop
// R17: Remote loop ignores transmit clock and data
// R18: All-ones from pin or control bit
// R19: All-ones is AMI at transmit clock rate
// R20: No all-ones in analog or remote loop
// R21: Loop select code decoded through a table
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ps

module lcdiag_channel
	import lcdiag_pkg::*;
(
	input  wire logic                  clk,                // 40 MHz system clock
	input  wire logic                  reset,              // Synchronous, active high
	input  wire logic                  psel,               // APB select
	input  wire logic                  penable,            // APB access phase
	input  wire logic                  pwrite,             // APB direction
	input  wire logic [APB_ADDR_W-1:0] paddr,              // APB byte address
	input  wire logic [31:0]           pwdata,             // APB write data
	output logic      [31:0]           prdata,             // APB read data
	output logic                       pready,             // APB ready
	output logic                       pslverr,            // APB error
	input  wire logic                  hostMode,           // Strap: 1 host, 0 hardware
	input  wire logic                  remoteLoopSelect,   // Hardware remote select pin
	input  wire logic                  localLoopSelect,    // Hardware local select pin
	input  wire logic                  allOnesSelect,      // Hardware all-ones pin
	input  wire logic                  txClockIn,          // Transmit clock from framer
	input  wire logic                  txPosDataIn,        // Transmit positive data
	input  wire logic                  txNegDataIn,        // Transmit negative data
	input  wire logic                  rxLinePos,          // Receive line positive
	input  wire logic                  rxLineNeg,          // Receive line negative
	input  wire logic                  rxCdrClock,         // Clock recovery output
	output logic                       txLinePos,          // Transmit line positive
	output logic                       txLineNeg,          // Transmit line negative
	output logic                       recoveredClock,     // Receive clock to framer
	output logic                       rxPosDataOut,       // Receive positive data
	output logic                       rxNegViolationOut   // Receive negative / violation
);

	// ***************************************************************
	// Pin synchronisers and edge detection
	// ***************************************************************
	logic [PIN_COUNT-1:0] pinMeta_reg;                     // First stage, read by second only
	logic [PIN_COUNT-1:0] pinSync_reg;                     // Second stage, used by logic
	logic                 txClkPrev_reg;                   // Last transmit clock level
	logic                 rxClkPrev_reg;                   // Last receive clock level

	// Two-flop capture of every asynchronous pin
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			pinMeta_reg <= '0;
			pinSync_reg <= '0;
		end
		else
		begin
			// Bit order follows the pin index constants, top bit first
			pinMeta_reg <= {allOnesSelect, localLoopSelect, remoteLoopSelect, hostMode,
				rxCdrClock, rxLineNeg, rxLinePos, txNegDataIn, txPosDataIn, txClockIn};
			pinSync_reg <= pinMeta_reg;
		end
	end

	logic         hostS;                                   // Host mode after sync
	logic         txClkS;                                  // Transmit clock after sync
	logic         rxClkSel;                                // Receive clock in use
	logic         txEdge;                                  // Rising transmit clock
	logic         rxStrobe;                                // Rising receive clock
	logic [7:0]   ctrl_reg;                                // Control register
	logic [1:0]   loopCode;                                // {remote, local} select
	lcdiag_loop_t loopMode;                                // Decoded loop mode
	logic         seqActive;                               // Sequence mode in force
	logic         allOnesActive;                           // All-ones in force
	logic         rateE3;                                  // Long sequence select

	assign hostS  = pinSync_reg[PIN_HOST];
	assign txClkS = pinSync_reg[PIN_TX_CLK];
	assign txEdge = txClkS & ~txClkPrev_reg;

	// R10: pins in hardware mode, bits in host mode
	assign loopCode = hostS ? {ctrl_reg[CTRL_REMOTE_SEL], ctrl_reg[CTRL_LOCAL_SEL]}
	                        : {pinSync_reg[PIN_HW_RLB], pinSync_reg[PIN_HW_LLB]};
	// R21: code to mode table
	assign loopMode = LOOP_TABLE[loopCode];
	// R13: digital loop takes its receive clock from transmit clock
	assign rxClkSel = (loopMode == LCD_DIGITAL) ? txClkS : pinSync_reg[PIN_RX_CLK];
	assign rxStrobe = rxClkSel & ~rxClkPrev_reg;
	// R1: sequence mode needs host mode
	assign seqActive = hostS & ctrl_reg[CTRL_SEQ_EN];
	assign rateE3    = ctrl_reg[CTRL_RATE_E3];
	// R18: all-ones from pin or control bit
	// R20: suppressed in analog and remote loop
	assign allOnesActive = (hostS ? ctrl_reg[CTRL_ALL_ONES] : pinSync_reg[PIN_HW_AONE]) &
		(loopMode != LCD_ANALOG) & (loopMode != LCD_REMOTE);

	// Previous clock levels for edge detection
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			txClkPrev_reg <= 1'b0;
			rxClkPrev_reg <= 1'b0;
		end
		else
		begin
			txClkPrev_reg <= txClkS;
			rxClkPrev_reg <= rxClkSel;
		end
	end

	// ***************************************************************
	// APB slave
	// ***************************************************************
	logic apbAccess;                                       // Access phase, answer cycle
	logic addrHit;                                         // Mapped address
	logic insertPending_reg;                               // Error awaiting a transmit bit
	logic locked_reg;                                      // Checker in lock

	assign apbAccess = psel & penable & pready;
	assign addrHit   = (paddr == ADDR_CTRL) | (paddr == ADDR_STATUS);

	// One wait state, then ready for one cycle
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end
		else
		begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~addrHit;
			if (psel & penable & ~pready & ~pwrite)
			begin
				// Read data loaded alongside ready
				if (paddr == ADDR_CTRL)
					prdata <= {24'h000000, ctrl_reg};
				else if (paddr == ADDR_STATUS)
					prdata <= {28'h0000000, loopMode, hostS, ~locked_reg};
				else
					prdata <= '0;
			end
		end
	end

	// Control register written at the completing edge
	always_ff @(posedge clk)
	begin
		if (reset)
			ctrl_reg <= CTRL_RESET;
		else if (apbAccess & pwrite & (paddr == ADDR_CTRL))
			ctrl_reg <= pwdata[7:0];
	end

	logic insertRise;                                      // Insert bit goes 0 to 1
	// R8: only a fresh 0-to-1 write arms an insertion
	assign insertRise = apbAccess & pwrite & (paddr == ADDR_CTRL) &
		pwdata[CTRL_ERR_INSERT] & ~ctrl_reg[CTRL_ERR_INSERT];

	// ***************************************************************
	// Transmit path
	// ***************************************************************
	logic                txBitStrobe;                      // Transmit bit time
	logic [SEQ_LEN-1:0]  gen_reg;                          // Generator state
	logic                genBit;                           // Next sequence bit
	logic                markPol_reg;                      // AMI polarity of next mark
	logic                rxPosCap_reg;                     // Last received positive
	logic                rxNegCap_reg;                     // Last received negative

	// R14: remote loop uses receive timing
	// R17: transmit clock ignored in remote loop
	assign txBitStrobe = (loopMode == LCD_REMOTE) ? rxStrobe : txEdge;
	// R2: tap choice sets 2^23-1 or 2^15-1
	assign genBit = rateE3 ? (gen_reg[TAP_A_E3] ^ gen_reg[TAP_B_E3])
	                       : (gen_reg[TAP_A_DS3] ^ gen_reg[TAP_B_DS3]);

	// Error insertion request, consumed by one sequence bit
	always_ff @(posedge clk)
	begin
		if (reset)
			insertPending_reg <= 1'b0;
		else if (insertRise & seqActive)
			insertPending_reg <= 1'b1;          // Set wins over consumption
		else if (~seqActive | txBitStrobe)
			insertPending_reg <= 1'b0;
	end

	// Generator steps once per transmit bit
	always_ff @(posedge clk)
	begin
		if (reset | ~seqActive)
			gen_reg <= {SEQ_LEN{1'b1}};
		else if (txBitStrobe)
			gen_reg <= {gen_reg[SEQ_LEN-2:0], genBit};
	end

	// Line output selection per bit time
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			txLinePos   <= 1'b0;
			txLineNeg   <= 1'b0;
			markPol_reg <= 1'b0;
		end
		else if (txBitStrobe)
		begin
			if (loopMode == LCD_REMOTE)
			begin
				// R14: received data resent to the line
				// R16: attenuator effect is outside; data order kept
				txLinePos <= rxPosCap_reg;
				txLineNeg <= rxNegCap_reg;
			end
			else if (allOnesActive)
			begin
				// R19: every bit a mark, alternating polarity
				txLinePos   <= ~markPol_reg;
				txLineNeg   <= markPol_reg;
				markPol_reg <= ~markPol_reg;
			end
			else if (seqActive)
			begin
				// R6: one bit inverted when armed
				// R9: single-rail bit, AMI on the line
				txLinePos   <= (genBit ^ insertPending_reg) & ~markPol_reg;
				txLineNeg   <= (genBit ^ insertPending_reg) & markPol_reg;
				markPol_reg <= markPol_reg ^ genBit ^ insertPending_reg;
			end
			else
			begin
				// Normal data from framer
				txLinePos <= pinSync_reg[PIN_TX_POS];
				txLineNeg <= pinSync_reg[PIN_TX_NEG];
			end
		end
	end

	// ***************************************************************
	// Receive path and checker
	// ***************************************************************
	logic               rxPosSrc;                          // Receive positive source
	logic               rxNegSrc;                          // Receive negative source
	logic               rxBit;                             // Single-rail receive bit
	logic [SEQ_LEN-1:0] hist_reg;                          // Received history
	logic               predBit;                           // Expected receive bit
	logic               errBit;                            // Detected bit error
	logic [7:0]         goodRun_reg;                       // Good bits while hunting
	logic [7:0]         badRun_reg;                        // Errors in a row while locked

	// Receive source per loop mode
	always_comb
	begin
		case (loopMode)
			LCD_ANALOG:
			begin
				// R11: own transmit line into the receiver
				// R12: receive line inputs not used
				rxPosSrc = txLinePos;
				rxNegSrc = txLineNeg;
			end
			LCD_DIGITAL:
			begin
				// R13: framer data straight back
				rxPosSrc = pinSync_reg[PIN_TX_POS];
				rxNegSrc = pinSync_reg[PIN_TX_NEG];
			end
			default:
			begin
				rxPosSrc = pinSync_reg[PIN_RX_POS];
				rxNegSrc = pinSync_reg[PIN_RX_NEG];
			end
		endcase
	end

	assign rxBit   = rxPosSrc | rxNegSrc;
	assign predBit = rateE3 ? (hist_reg[TAP_A_E3] ^ hist_reg[TAP_B_E3])
	                        : (hist_reg[TAP_A_DS3] ^ hist_reg[TAP_B_DS3]);
	assign errBit  = rxBit ^ predBit;

	// Capture and deliver receive data, one bit per receive clock
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			rxPosCap_reg      <= 1'b0;
			rxNegCap_reg      <= 1'b0;
			rxPosDataOut      <= 1'b0;
			rxNegViolationOut <= 1'b0;
			recoveredClock    <= 1'b0;
		end
		else
		begin
			recoveredClock <= rxClkSel;
			if (rxStrobe)
			begin
				rxPosCap_reg <= rxPosSrc;
				rxNegCap_reg <= rxNegSrc;
				if (seqActive)
				begin
					// R9: single-rail data on positive output
					// R5: high while out of lock
					// R7: high one receive cycle per error
					rxPosDataOut      <= rxBit;
					rxNegViolationOut <= ~locked_reg | errBit;
				end
				else
				begin
					// R15: received data delivered in every loop
					rxPosDataOut      <= rxPosSrc;
					rxNegViolationOut <= rxNegSrc;
				end
			end
		end
	end

	// R3: checker runs exactly when the generator does
	always_ff @(posedge clk)
	begin
		if (reset | ~seqActive)
		begin
			hist_reg    <= '0;
			goodRun_reg <= '0;
			badRun_reg  <= '0;
			locked_reg  <= 1'b0;
		end
		else if (rxStrobe)
		begin
			hist_reg <= {hist_reg[SEQ_LEN-2:0], rxBit};
			if (~locked_reg)
			begin
				// R4: lock after a run of good bits
				goodRun_reg <= errBit ? 8'h00 : goodRun_reg + 8'h01;
				locked_reg  <= ~errBit & (goodRun_reg == LOCK_GOOD_BITS - 8'h01);
				badRun_reg  <= '0;
			end
			else
			begin
				// Lock lost after errors in a row
				badRun_reg  <= errBit ? badRun_reg + 8'h01 : 8'h00;
				locked_reg  <= ~(errBit & (badRun_reg == LOSS_ERR_BITS - 8'h01));
				goodRun_reg <= '0;
			end
		end
	end

	// ***************************************************************
	// Assertions
	// ***************************************************************
	AST_HW_NO_SEQ: // R1
		assert property (@(posedge clk) disable iff (reset) !hostS |-> !seqActive)
		else $error("sequence mode active in hardware mode");

	AST_SEQ_TAPS: // R2
		assert property (@(posedge clk) disable iff (reset)
			seqActive && txBitStrobe && loopMode != LCD_REMOTE && !allOnesActive
			&& !insertPending_reg |=> (txLinePos | txLineNeg) == $past(genBit))
		else $error("transmitted bit differs from sequence");

	AST_CHECK_OFF: // R3
		assert property (@(posedge clk) disable iff (reset)
			!seqActive |=> !locked_reg && goodRun_reg == 8'h00)
		else $error("checker running without sequence mode");

	AST_LOCK_LOW: // R4
		assert property (@(posedge clk) disable iff (reset)
			seqActive && locked_reg && rxStrobe && !errBit |=> !rxNegViolationOut)
		else $error("violation output high while locked and clean");

	AST_UNLOCK_HIGH: // R5
		assert property (@(posedge clk) disable iff (reset)
			seqActive && !locked_reg && rxStrobe |=> rxNegViolationOut)
		else $error("violation output low while out of lock");

	AST_INSERT_ONCE: // R6
		assert property (@(posedge clk) disable iff (reset)
			insertPending_reg && txBitStrobe && !insertRise |=> !insertPending_reg)
		else $error("inserted error not consumed by one bit");

	AST_ERR_PULSE: // R7
		assert property (@(posedge clk) disable iff (reset)
			seqActive && locked_reg && rxStrobe && errBit
			|=> rxNegViolationOut throughout (!rxStrobe [*2]))
		else $error("error pulse shorter than a receive cycle");

	AST_NO_REARM: // R8
		assert property (@(posedge clk) disable iff (reset)
			!insertPending_reg && ctrl_reg[CTRL_ERR_INSERT] && !(apbAccess && pwrite)
			|=> !insertPending_reg)
		else $error("insertion armed without a new rising write");

	AST_ANALOG_FEED: // R11
		assert property (@(posedge clk) disable iff (reset)
			loopMode == LCD_ANALOG && rxStrobe && !seqActive
			|=> rxPosDataOut == $past(txLinePos) && rxNegViolationOut == $past(txLineNeg))
		else $error("analog loop did not feed transmit line back");

	AST_DIGITAL_PASS: // R13
		assert property (@(posedge clk) disable iff (reset)
			loopMode == LCD_DIGITAL && rxStrobe && !seqActive
			|=> rxPosDataOut == $past(pinSync_reg[PIN_TX_POS]))
		else $error("digital loop did not pass transmit data");

	AST_REMOTE_RESEND: // R14
		assert property (@(posedge clk) disable iff (reset)
			loopMode == LCD_REMOTE && rxStrobe
			|=> txLinePos == $past(rxPosCap_reg) && txLineNeg == $past(rxNegCap_reg))
		else $error("remote loop did not resend received data");

	AST_ONES_AMI: // R19
		assert property (@(posedge clk) disable iff (reset)
			allOnesActive && txBitStrobe |=> txLinePos != txLineNeg)
		else $error("all-ones did not send a mark");

	AST_ONES_BLOCKED: // R20
		assert property (@(posedge clk) disable iff (reset)
			loopMode == LCD_ANALOG || loopMode == LCD_REMOTE |-> !allOnesActive)
		else $error("all-ones active in analog or remote loop");

endmodule // lcdiag_channel

/* hdl/lcdiag_pkg.sv */
// Constants and types for one line channel's diagnostic logic.
// Assumes a 40 MHz system clock and an APB register bus with 32-bit data.
package lcdiag_pkg;

	// ***************************************************************
	// Register map
	// ***************************************************************
	localparam int          APB_ADDR_W  = 12;              // Byte address width
	localparam logic [11:0] ADDR_CTRL   = 12'h000;         // Channel control
	localparam logic [11:0] ADDR_STATUS = 12'h004;         // Channel status
	localparam logic [7:0]  CTRL_RESET  = 8'h00;           // Control after reset

	// Control field positions
	localparam int CTRL_SEQ_EN     = 0;                    // Sequence mode enable
	localparam int CTRL_ERR_INSERT = 1;                    // Single error insert
	localparam int CTRL_REMOTE_SEL = 2;                    // Remote loop select
	localparam int CTRL_LOCAL_SEL  = 3;                    // Local loop select
	localparam int CTRL_ALL_ONES   = 4;                    // All-ones transmit
	localparam int CTRL_RATE_E3    = 5;                    // 1: E3, 0: DS3/STS-1
	localparam int CTRL_JA_TX      = 6;                    // Attenuator in tx path

	// Status field positions
	localparam int STAT_LOCK_LOST  = 0;                    // Checker out of lock
	localparam int STAT_HOST_MODE  = 1;                    // Host mode strap
	localparam int STAT_LOOP_LSB   = 2;                    // Active loop mode, 2 bits

	// ***************************************************************
	// Sequence generator and checker
	// ***************************************************************
	localparam int SEQ_LEN   = 23;                         // Longest register
	localparam int TAP_A_E3  = 22;                         // x^23 term
	localparam int TAP_B_E3  = 17;                         // x^18 term
	localparam int TAP_A_DS3 = 14;                         // x^15 term
	localparam int TAP_B_DS3 = 13;                         // x^14 term
	localparam logic [7:0] LOCK_GOOD_BITS = 8'h20;         // Good bits to lock
	localparam logic [7:0] LOSS_ERR_BITS  = 8'h04;         // Errors in a row to unlock

	// ***************************************************************
	// Pin synchroniser layout
	// ***************************************************************
	localparam int PIN_TX_CLK  = 0;                        // Transmit clock
	localparam int PIN_TX_POS  = 1;                        // Transmit positive data
	localparam int PIN_TX_NEG  = 2;                        // Transmit negative data
	localparam int PIN_RX_POS  = 3;                        // Receive line positive
	localparam int PIN_RX_NEG  = 4;                        // Receive line negative
	localparam int PIN_RX_CLK  = 5;                        // Clock recovery output
	localparam int PIN_HOST    = 6;                        // Host mode strap
	localparam int PIN_HW_RLB  = 7;                        // Hardware remote select
	localparam int PIN_HW_LLB  = 8;                        // Hardware local select
	localparam int PIN_HW_AONE = 9;                        // Hardware all-ones
	localparam int PIN_COUNT   = 10;                       // Synchronised pins

	// ***************************************************************
	// Loop modes, indexed by {remote select, local select}
	// ***************************************************************
	typedef enum logic [1:0] {LCD_NORMAL, LCD_ANALOG, LCD_DIGITAL, LCD_REMOTE} lcdiag_loop_t;
	localparam lcdiag_loop_t LOOP_TABLE [4] = '{LCD_NORMAL, LCD_ANALOG, LCD_REMOTE, LCD_DIGITAL};

endpackage

/* verification/lcdiag_framer_model.sv */
// Framer model: transmit clock and data, plus a recovery clock.
// Assumes the bench seeds $urandom; both clocks run at clk/16.
`timescale 1ns/1ps

module lcdiag_framer_model
(
	input  wire logic clk,          // System clock
	output logic      txClockIn,    // Transmit clock
	output logic      txPosDataIn,  // Transmit positive data
	output logic      txNegDataIn,  // Transmit negative data
	output logic      rxCdrClock    // Recovery clock, quarter bit early
);
	logic [3:0] phase_reg = 4'h0;   // Position within one bit
	logic [3:0] rxPhase;            // Shifted phase
	logic [1:0] data_reg = 2'h0;    // Transmit rails

	// ***************************************************************
	// Clocks and data
	// ***************************************************************
	// Bit counter; data moves on the same edge as the falling edge
	always @(posedge clk)
	begin
		phase_reg <= phase_reg + 4'h1;
		if (phase_reg == 4'hf)
			data_reg <= 2'($urandom);
	end
	assign rxPhase = phase_reg + 4'h4;
	assign txClockIn = phase_reg[3];
	assign rxCdrClock = rxPhase[3];
	assign {txPosDataIn, txNegDataIn} = data_reg;
endmodule // lcdiag_framer_model

/* verification/tb_top.sv */
// Self-checking bench for lcdiag_channel with a framer model.
// Assumes one APB wait state; expectations queue to two monitors.
`timescale 1ns/1ps

module tb_top
	import lcdiag_pkg::*;
;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic psel, penable, pwrite, pready, pslverr, hostMode, rSel, lSel, aOne;
	logic txClk, txP, txN, cdr, rxP, rxN, lineP, lineN, recClk, outP, outV;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, v;
	logic [32:0] expQ[$], maskQ[$], probeVal;
	logic prevP, prevV, prevN;
	int fails = 0, checksDone = 0, c, j;
	event probe;
	localparam logic [1:0] MODE [4] = '{2'h0, 2'h1, 2'h3, 2'h2};

	always #12.5 clk = ~clk;

	lcdiag_framer_model lcdiag_framer_model_i (.clk(clk), .txClockIn(txClk),
		.txPosDataIn(txP), .txNegDataIn(txN), .rxCdrClock(cdr));
	lcdiag_channel lcdiag_channel_i (.clk(clk), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .hostMode(hostMode),
		.remoteLoopSelect(rSel), .localLoopSelect(lSel), .allOnesSelect(aOne),
		.txClockIn(txClk), .txPosDataIn(txP), .txNegDataIn(txN), .rxLinePos(rxP),
		.rxLineNeg(rxN), .rxCdrClock(cdr), .txLinePos(lineP), .txLineNeg(lineN),
		.recoveredClock(recClk), .rxPosDataOut(outP), .rxNegViolationOut(outV));

	// ***************************************************************
	// Checking
	// ***************************************************************
	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		checksDone++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", checksDone, fails);
		if (fails == 0 && checksDone > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic note(input logic [32:0] m, input logic [32:0] e);
		maskQ.push_back(m);
		expQ.push_back(e);
	endtask

	// Read data with error flag, at the accepting edge
	always @(posedge clk)
		if (psel && penable && pready && !pwrite && maskQ.size() > 0)
			check({pslverr, prdata} & maskQ.pop_front(), expQ.pop_front());
	// Pin samples handed over by the driver
	always @(probe)
		check(probeVal & maskQ.pop_front(), expQ.pop_front());

	task automatic look(input logic [32:0] seen, input logic [32:0] e);
		note(33'h1ffffffff, e);
		probeVal = seen;
		->probe;
		@(posedge clk);
	endtask

	// ***************************************************************
	// Drivers
	// ***************************************************************
	// One APB transfer, held until pready
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (n >= 20)
		begin
			fails++;
			test_done;
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	// Wait for a clock rise from the model, then six cycles
	task automatic tick(input logic rx);
		int n;
		logic p, q;
		p = 1'b1;
		q = 1'b1;
		for (n = 0; n < 40 && !(p == 1'b0 && q == 1'b1); n++)
		begin
			p = q;
			@(posedge clk);
			q = rx ? cdr : txClk;
		end
		if (n >= 40)
		begin
			fails++;
			test_done;
		end
		repeat (6) @(posedge clk);
	endtask

	// Rising edges of the violation output
	task automatic pulses(output int cnt);
		cnt = 0;
		repeat (1200)
		begin
			@(posedge clk);
			cnt += (outV === 1'b1 && prevV === 1'b0) ? 1 : 0;
			prevV = outV;
		end
	endtask

	// ***************************************************************
	// Scenarios
	// ***************************************************************
	initial
	begin
		{psel, penable, pwrite, rSel, lSel, aOne, rxP, rxN} = 8'h00;
		{paddr, pwdata, hostMode} = {44'h0, 1'b1};
		void'($urandom(32'hf126));
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		note(33'h1ffffffff, {25'h0, CTRL_RESET});
		apb(1'b0, ADDR_CTRL, 32'h0);
		note(33'h1ffffffff, 33'h100000000);
		apb(1'b0, 12'h008, 32'h0);
		v = $urandom() & 32'h0000007f;
		apb(1'b1, ADDR_CTRL, v);
		note(33'h1ffffffff, {1'b0, v});
		apb(1'b0, ADDR_CTRL, 32'h0);
		// Loop codes from register, then from pins
		for (j = 0; j < 8; j++)
		begin
			hostMode <= !j[2];
			rSel <= j[1] ^ !j[2];
			lSel <= j[0] ^ !j[2];
			apb(1'b1, ADDR_CTRL, {28'h0, j[0] ^ j[2], j[1] ^ j[2], 2'h0});
			note(33'h00000000e, {29'h0, MODE[j[1:0]], !j[2], 1'b0});
			apb(1'b0, ADDR_STATUS, 32'h0);
		end
		{hostMode, rSel, lSel} <= 3'b100;
		apb(1'b1, ADDR_CTRL, 32'h0000000c);
		repeat (4)
		begin
			tick(1'b0);
			look({30'h0, recClk, outP, outV}, {30'h0, 1'b1, txP, txN});
		end
		apb(1'b1, ADDR_CTRL, 32'h0000001c);
		tick(1'b0);
		prevP = lineP;
		repeat (4)
		begin
			tick(1'b0);
			look({31'h0, lineP ^ lineN, lineP ^ prevP}, 33'h3);
			prevP = lineP;
		end
		{rxP, rxN} <= 2'b10;
		apb(1'b1, ADDR_CTRL, 32'h00000018);
		tick(1'b0);
		{prevP, prevN} = {lineP, lineN};
		repeat (2)
		begin
			tick(1'b0);
			look({31'h0, outP ^ prevP, outV ^ prevN}, 33'h0);
			{prevP, prevN} = {lineP, lineN};
		end
		apb(1'b1, ADDR_CTRL, 32'h00000014);
		repeat (4) tick(1'b1);
		look({30'h0, lineP, lineN, outP}, 33'h5);
		{rxP, rxN} <= 2'b11;
		for (j = 0; j < 2; j++)
		begin
			v = {26'h0, j[0], 5'h09};
			apb(1'b1, ADDR_CTRL, 32'h0);
			apb(1'b1, ADDR_CTRL, v);
			note(33'h000000001, 33'h1);
			apb(1'b0, ADDR_STATUS, 32'h0);
			repeat (1500) @(posedge clk);
			note(33'h000000001, 33'h0);
			apb(1'b0, ADDR_STATUS, 32'h0);
			look({32'h0, outV}, 33'h0);
			apb(1'b1, ADDR_CTRL, v | 32'h2);
			pulses(c);
			look({32'h0, c != 0}, 33'h1);
			apb(1'b1, ADDR_CTRL, v | 32'h2);
			pulses(c);
			look({32'h0, c == 0}, 33'h1);
		end
		test_done;
	end
endmodule // tb_top
